// file: inc/drive_side_pkg.sv
// shared constants, types and states of the drive-side signal block
package drive_side_pkg;
    // clock and timing, times in ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int DIR_SETUP_NS = 12000;
    localparam int STEP_PULSE_NS = 4000;
    localparam int BIT_CELL_NS = 4000;
    localparam int WR_PULSE_NS = 500;
    // least times round up to whole cycles
    localparam logic [7:0] DIR_SETUP_CYC = 8'((DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] STEP_PULSE_CYC = 8'((STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] BIT_CELL_CYC = 8'((BIT_CELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WR_PULSE_CYC = 8'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // register addresses
    localparam logic [1:0] ADDR_STATUS_CMD = 2'h0;
    localparam logic [1:0] ADDR_TRACK = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h3;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_REQ = 1;
    localparam int ST_GATE = 4;
    localparam int ST_SETTLED = 5;
    localparam int ST_FULL = 6;
    localparam int ST_IRQ = 7;
    // command opcodes
    localparam logic [1:0] OP_STEP_IN = 2'h0;
    localparam logic [1:0] OP_STEP_OUT = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h3;
    // tracks: inner zone is 44 to 76
    localparam logic [6:0] ZONE_FIRST = 7'h2c;
    localparam logic [6:0] ZONE_LAST = 7'h4c;
    localparam logic [6:0] TRACK_MAX = 7'h4c;
    // reset values
    localparam logic [6:0] TRACK_RST = 7'h00;
    localparam logic [7:0] HOLD_RST = 8'h00;
    localparam logic SIDE_RST = 1'b0;
    // register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    // command byte layout
    typedef struct packed {
        logic [1:0] op;
        logic [1:0] spare_hi;
        logic side;
        logic [2:0] spare_lo;
    } cmd_s;
    typedef enum logic [5:0] {
        s_idle = 6'h01,
        s_dir = 6'h02,
        s_step = 6'h04,
        s_settle = 6'h08,
        s_read = 6'h10,
        s_write = 6'h20
    } state_e;
endpackage

// file: src/pin_sync.sv
// two-stage synchroniser with edge detection for outside pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            logic prev_r;
            // meta_r feeds only sync_r; edges come from the settled stages
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    meta_r <= pin_in[i];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign level[i] = sync_r;
            assign rise[i] = sync_r & ~prev_r;
            assign fall[i] = ~sync_r & prev_r;
        end
    endgenerate
endmodule
`default_nettype wire

// file: src/drive_side_ctrl.sv
// drive-side signals, transfer request and completion flag of the disk controller
// Behaviour
// - request when byte assembled, or holding empty
// - host data access clears the request
// - completion flag set when any command ends
// - status read or command write clears flag
// - one step pulse per track moved
// - direction high inward, low outward
// - early held high during advanced pulse
// - late held high during delayed pulse
// - settled input high means head engaged
// - sync gate rises after run of equal bits
// - side output follows read/write command side flag
// - side changes only at command start
// - side output low during reset
// - head load output engages the head
// - inner zone on tracks 44 to 76
// - inner zone valid only during read/write
// - write gate up before any write data
`timescale 1ns/1ns
`default_nettype none
module drive_side_ctrl #(
    parameter int SYNC_RUN = 16,
    parameter int BYTES_PER_CMD = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire drive_side_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic head_settled_in,
    input wire logic raw_read_n,
    input wire logic read_clock,
    output logic step_out,
    output logic step_direction,
    output logic early_out,
    output logic late_out,
    output logic write_data_out,
    output logic write_gate_out,
    output logic head_load_out,
    output logic sync_field_gate,
    output logic side_select_out,
    output logic inner_track_zone,
    output logic transfer_request,
    output logic command_done_irq,
    output logic transfer_request_pin_out,
    output logic transfer_request_oe_n,
    output logic command_done_irq_pin_out,
    output logic command_done_irq_oe_n
);
    localparam logic [7:0] SYNC_N = 8'(SYNC_RUN);
    localparam logic [7:0] BYTES_N = 8'(BYTES_PER_CMD);

    drive_side_pkg::state_e state_r, state_nxt;
    drive_side_pkg::cmd_s cmd;
    logic [2:0] pin_level, pin_rise, pin_fall;
    logic settled, raw_fall, win;
    logic [7:0] cnt_r, pcnt_r, run_r, rshift_r, wshift_r, hold_r, bytes_r, status;
    logic [2:0] rbits_r, wbits_r;
    logic [6:0] track_r;
    logic [1:0] op_r;
    logic req_r, irq_r, side_r, dir_r, step_r, hld_r, zone_r, gate_r;
    logic pulse_seen_r, last_bit_r, hold_full_r, wr_run_r, tail_r;
    logic wd_r, early_r, late_r, prev_bit_r;
    logic cmd_wr, status_rd, data_rd, data_wr, track_wr, start, rw_start, cmd_done;
    logic bit_now, byte_ready, bit_en, load_first, load_next, cur_bit, next_bit;
    logic req_set, req_clr;

    // pins from the drive pass two flops first
    pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .pin_in({read_clock, raw_read_n, head_settled_in}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );
    assign settled = pin_level[0];
    assign raw_fall = pin_fall[1];
    // either read clock edge closes a window, so polarity does not matter
    assign win = pin_rise[2] | pin_fall[2];

    // register port decode
    assign cmd = drive_side_pkg::cmd_s'(reg_req.wdata);
    assign cmd_wr = reg_req.wr && reg_req.addr == drive_side_pkg::ADDR_STATUS_CMD;
    assign status_rd = reg_req.rd && reg_req.addr == drive_side_pkg::ADDR_STATUS_CMD;
    assign data_rd = reg_req.rd && reg_req.addr == drive_side_pkg::ADDR_DATA;
    assign data_wr = reg_req.wr && reg_req.addr == drive_side_pkg::ADDR_DATA;
    assign track_wr = reg_req.wr && reg_req.addr == drive_side_pkg::ADDR_TRACK;
    // a command written while busy is dropped, only the flag clear acts
    assign start = cmd_wr && state_r == drive_side_pkg::s_idle;
    assign rw_start = start && cmd.op[1];

    // read path strobes
    assign bit_now = pulse_seen_r | raw_fall;
    assign byte_ready = state_r == drive_side_pkg::s_read && gate_r && win && rbits_r == 3'h7;
    // write path strobes
    assign bit_en = state_r == drive_side_pkg::s_write && wr_run_r && cnt_r == 8'h00;
    assign load_first = state_r == drive_side_pkg::s_write && !wr_run_r && hold_full_r;
    assign load_next = bit_en && !tail_r && wbits_r == 3'h7 && bytes_r != BYTES_N;
    assign cur_bit = wshift_r[7];
    assign next_bit = (wbits_r == 3'h7) ? (hold_full_r & hold_r[7]) : wshift_r[6];

    // command sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            drive_side_pkg::s_idle: begin
                if (start) begin
                    state_nxt = cmd.op[1] ? drive_side_pkg::s_settle : drive_side_pkg::s_dir;
                end
            end
            drive_side_pkg::s_dir: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = drive_side_pkg::s_step;
                end
            end
            drive_side_pkg::s_step: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = drive_side_pkg::s_idle;
                end
            end
            drive_side_pkg::s_settle: begin
                // nothing moves until the head reports engaged
                if (settled) begin
                    state_nxt = (op_r == drive_side_pkg::OP_WRITE) ?
                        drive_side_pkg::s_write : drive_side_pkg::s_read;
                end
            end
            drive_side_pkg::s_read: begin
                if (byte_ready && bytes_r == BYTES_N - 8'h01) begin
                    state_nxt = drive_side_pkg::s_idle;
                end
            end
            drive_side_pkg::s_write: begin
                // the tail cell lets the last flux pulse finish under the gate
                if (bit_en && tail_r) begin
                    state_nxt = drive_side_pkg::s_idle;
                end
            end
        endcase
    end
    assign cmd_done = state_r != drive_side_pkg::s_idle && state_nxt == drive_side_pkg::s_idle;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= drive_side_pkg::s_idle;
        end else begin
            state_r <= state_nxt;
        end
    end

    // shared timer: direction setup, step width, bit cell
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 8'h00;
        end else if (start) begin
            cnt_r <= drive_side_pkg::DIR_SETUP_CYC - 8'h01;
        end else if (state_r == drive_side_pkg::s_dir && cnt_r == 8'h00) begin
            cnt_r <= drive_side_pkg::STEP_PULSE_CYC - 8'h01;
        end else if (load_first || bit_en) begin
            cnt_r <= drive_side_pkg::BIT_CELL_CYC - 8'h01;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // latched command fields; side only moves at a read/write start
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            op_r <= drive_side_pkg::OP_STEP_IN;
            dir_r <= 1'b0;
            side_r <= drive_side_pkg::SIDE_RST;
        end else if (start) begin
            op_r <= cmd.op;
            if (rw_start) begin
                side_r <= cmd.side;
            end else begin
                dir_r <= cmd.op == drive_side_pkg::OP_STEP_IN;
            end
        end
    end

    // step pulse and track position
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            step_r <= 1'b0;
            track_r <= drive_side_pkg::TRACK_RST;
        end else begin
            step_r <= state_nxt == drive_side_pkg::s_step;
            if (state_r == drive_side_pkg::s_step && cnt_r == 8'h00) begin
                if (dir_r && track_r != drive_side_pkg::TRACK_MAX) begin
                    track_r <= track_r + 7'h01;
                end else if (!dir_r && track_r != 7'h00) begin
                    track_r <= track_r - 7'h01;
                end
            end else if (track_wr && state_r == drive_side_pkg::s_idle) begin
                track_r <= reg_req.wdata[6:0];
            end
        end
    end

    // head load and zone, both only while a read/write runs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hld_r <= 1'b0;
            zone_r <= 1'b0;
        end else begin
            hld_r <= state_nxt == drive_side_pkg::s_settle ||
                     state_nxt == drive_side_pkg::s_read ||
                     state_nxt == drive_side_pkg::s_write;
            zone_r <= (state_nxt == drive_side_pkg::s_settle ||
                       state_nxt == drive_side_pkg::s_read ||
                       state_nxt == drive_side_pkg::s_write) &&
                      track_r >= drive_side_pkg::ZONE_FIRST &&
                      track_r <= drive_side_pkg::ZONE_LAST;
        end
    end

    // read: hunt for a run of equal windows, then assemble bytes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pulse_seen_r <= 1'b0;
            last_bit_r <= 1'b0;
            run_r <= 8'h00;
            gate_r <= 1'b0;
            rshift_r <= 8'h00;
            rbits_r <= 3'h0;
        end else if (state_r != drive_side_pkg::s_read) begin
            pulse_seen_r <= 1'b0;
            run_r <= 8'h00;
            gate_r <= 1'b0;
            rbits_r <= 3'h0;
        end else begin
            pulse_seen_r <= win ? 1'b0 : bit_now;
            if (win && !gate_r) begin
                last_bit_r <= bit_now;
                if (bit_now == last_bit_r && run_r != 8'h00) begin
                    run_r <= (run_r == 8'hff) ? run_r : run_r + 8'h01;
                    if (run_r >= SYNC_N - 8'h01) begin
                        gate_r <= 1'b1;
                    end
                end else begin
                    run_r <= 8'h01;
                end
            end else if (win) begin
                rshift_r <= {rshift_r[6:0], bit_now};
                rbits_r <= rbits_r + 3'h1;
            end
        end
    end

    // holding register: host or disk side fills it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_r <= drive_side_pkg::HOLD_RST;
            hold_full_r <= 1'b0;
        end else begin
            if (byte_ready) begin
                hold_r <= {rshift_r[6:0], bit_now};
            end else if (data_wr) begin
                hold_r <= reg_req.wdata;
            end
            // a host load in the same cycle as a drain keeps it full
            hold_full_r <= data_wr | (hold_full_r & ~(load_first | load_next));
        end
    end

    // write: serialise bytes into flux pulses under the gate
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_run_r <= 1'b0;
            tail_r <= 1'b0;
            wshift_r <= 8'h00;
            wbits_r <= 3'h0;
            bytes_r <= 8'h00;
            prev_bit_r <= 1'b0;
        end else if (state_r != drive_side_pkg::s_write && state_r != drive_side_pkg::s_read) begin
            wr_run_r <= 1'b0;
            tail_r <= 1'b0;
            wbits_r <= 3'h0;
            bytes_r <= 8'h00;
            prev_bit_r <= 1'b0;
        end else if (byte_ready) begin
            bytes_r <= bytes_r + 8'h01;
        end else if (load_first) begin
            wr_run_r <= 1'b1;
            wshift_r <= hold_r;
            bytes_r <= 8'h01;
        end else if (bit_en && !tail_r) begin
            prev_bit_r <= cur_bit;
            wbits_r <= wbits_r + 3'h1;
            if (wbits_r != 3'h7) begin
                wshift_r <= {wshift_r[6:0], 1'b0};
            end else if (bytes_r == BYTES_N) begin
                tail_r <= 1'b1;
            end else begin
                // an underrun writes zeros rather than stalling the disk
                wshift_r <= hold_full_r ? hold_r : 8'h00;
                bytes_r <= bytes_r + 8'h01;
            end
        end
    end

    // flux pulse with its precompensation marks, inner zone only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wd_r <= 1'b0;
            early_r <= 1'b0;
            late_r <= 1'b0;
            pcnt_r <= 8'h00;
        end else if (bit_en && !tail_r && cur_bit) begin
            wd_r <= 1'b1;
            early_r <= zone_r & prev_bit_r & ~next_bit;
            late_r <= zone_r & ~prev_bit_r & next_bit;
            pcnt_r <= drive_side_pkg::WR_PULSE_CYC - 8'h01;
        end else if (pcnt_r != 8'h00) begin
            pcnt_r <= pcnt_r - 8'h01;
        end else begin
            wd_r <= 1'b0;
            early_r <= 1'b0;
            late_r <= 1'b0;
        end
    end

    // transfer request and completion flag; a set beats a clear
    assign req_set = byte_ready || load_first || load_next ||
                     (state_nxt == drive_side_pkg::s_write &&
                      state_r == drive_side_pkg::s_settle && !hold_full_r);
    assign req_clr = start || (op_r == drive_side_pkg::OP_READ && data_rd) ||
                     (op_r == drive_side_pkg::OP_WRITE && data_wr);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            req_r <= req_set | (req_r & ~req_clr);
            irq_r <= cmd_done | (irq_r & ~(status_rd | cmd_wr));
        end
    end

    // register read data, valid only the cycle after the strobe
    always_comb begin
        status = 8'h00;
        status[drive_side_pkg::ST_BUSY] = state_r != drive_side_pkg::s_idle;
        status[drive_side_pkg::ST_REQ] = req_r;
        status[drive_side_pkg::ST_GATE] = gate_r;
        status[drive_side_pkg::ST_SETTLED] = settled;
        status[drive_side_pkg::ST_FULL] = hold_full_r;
        status[drive_side_pkg::ST_IRQ] = irq_r;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (!reg_req.rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_req.addr)
                drive_side_pkg::ADDR_STATUS_CMD: reg_rdata <= status;
                drive_side_pkg::ADDR_TRACK: reg_rdata <= {1'b0, track_r};
                drive_side_pkg::ADDR_DATA: reg_rdata <= hold_r;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // outputs
    assign step_out = step_r;
    assign step_direction = dir_r;
    assign early_out = early_r;
    assign late_out = late_r;
    assign write_data_out = wd_r;
    // gate rises on entering the write phase, at least a bit cell before the first pulse
    assign write_gate_out = state_r == drive_side_pkg::s_write;
    assign head_load_out = hld_r;
    assign sync_field_gate = gate_r;
    assign side_select_out = side_r;
    assign inner_track_zone = zone_r;
    assign transfer_request = req_r;
    assign command_done_irq = irq_r;
    // open-drain: pull low only while the flag is set
    assign transfer_request_pin_out = 1'b0;
    assign transfer_request_oe_n = ~req_r;
    assign command_done_irq_pin_out = 1'b0;
    assign command_done_irq_oe_n = ~irq_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_req_on_byte: assert property (byte_ready |=> transfer_request)
        else $error("request not raised for assembled byte");
    a_req_serviced: assert property ((data_rd && op_r == drive_side_pkg::OP_READ && !req_set)
        |=> !transfer_request)
        else $error("request not cleared by data read");
    a_irq_on_done: assert property (cmd_done |=> command_done_irq)
        else $error("completion flag not set");
    a_irq_clear: assert property ((status_rd && !cmd_done) |=> !command_done_irq)
        else $error("completion flag not cleared");
    a_step_once: assert property ($fell(step_out) |-> $past(cmd_done))
        else $error("step pulse did not end the command");
    a_step_dir: assert property (step_out |->
        step_direction == (op_r == drive_side_pkg::OP_STEP_IN))
        else $error("wrong step direction");
    a_dir_setup: assert property ($rose(step_out) |->
        $past(step_direction, 8) == step_direction)
        else $error("direction changed just before step");
    a_dir_hold: assert property (step_out |-> $stable(step_direction))
        else $error("direction changed during step");
    a_early_pulse: assert property (early_out |-> write_data_out && !late_out)
        else $error("early mark outside write pulse");
    a_late_pulse: assert property (late_out |-> write_data_out)
        else $error("late mark outside write pulse");
    a_head_wait: assert property ((state_r == drive_side_pkg::s_settle && !settled)
        |=> state_r == drive_side_pkg::s_settle)
        else $error("left settle wait without engaged head");
    a_gate_run: assert property ($rose(sync_field_gate) |->
        $past(run_r) >= SYNC_N - 8'h01)
        else $error("sync gate raised before full run");
    a_side_stable: assert property ($changed(side_select_out) |-> $past(rw_start))
        else $error("side changed outside command start");
    a_zone_valid: assert property (inner_track_zone |-> head_load_out &&
        track_r >= drive_side_pkg::ZONE_FIRST && track_r <= drive_side_pkg::ZONE_LAST)
        else $error("inner zone asserted wrongly");
    a_gate_first: assert property (write_data_out |->
        write_gate_out && $past(write_gate_out, 2))
        else $error("write data without write gate");
endmodule
`default_nettype wire

// file: bench/drive_model.sv
// drive and data separator model: head settle, read clock, flux pulses
`timescale 1ns/1ns
`default_nettype none
module drive_model (
    input wire logic head_load_out,
    output logic head_settled_in,
    output logic read_clock,
    output logic raw_read_n
);
    // head engages about 2 us after load, off the clock edges; a slow drive, so the design waits
    initial begin
        head_settled_in = 1'b0;
        forever begin
            @(head_load_out);
            head_settled_in <= #2030 head_load_out;
        end
    end
    // clock runs only while the head is engaged; one flux pulse per half period
    initial begin
        read_clock = 1'b0;
        raw_read_n = 1'b1;
        forever begin
            if (head_settled_in === 1'b1) begin
                read_clock = ~read_clock;
                // the low pulse spans two rising edges, so no edge races it
                #120 raw_read_n = 1'b0;
                #160 raw_read_n = 1'b1;
                #120;
            end else begin
                #400;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// register-level tests of the drive-side block against the drive model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock = 1'b0, rstn = 1'b0, sett, rclk, raw_n;
    drive_side_pkg::reg_req_s req = '0;
    logic [7:0] rdata, v;
    logic st, dir, early, late, wd, wg, hl, sg, side, zone, trq, irq, trq_oe_n, irq_oe_n;
    int failures = 0, tests_run = 0, steps = 0, wpulses = 0, bad = 0;
    always #50 clock = ~clock;
    drive_side_ctrl #(.SYNC_RUN(4), .BYTES_PER_CMD(2)) dut (.clock(clock), .rstn(rstn),
        .reg_req(req), .reg_rdata(rdata), .head_settled_in(sett), .raw_read_n(raw_n),
        .read_clock(rclk), .step_out(st), .step_direction(dir), .early_out(early),
        .late_out(late), .write_data_out(wd), .write_gate_out(wg), .head_load_out(hl),
        .sync_field_gate(sg), .side_select_out(side), .inner_track_zone(zone),
        .transfer_request(trq), .command_done_irq(irq), .transfer_request_pin_out(),
        .transfer_request_oe_n(trq_oe_n), .command_done_irq_pin_out(),
        .command_done_irq_oe_n(irq_oe_n));
    drive_model far (.head_load_out(hl), .head_settled_in(sett), .read_clock(rclk),
        .raw_read_n(raw_n));
    logic st_q = 1'b0, wd_q = 1'b0, dir_q = 1'b0;
    int epulses = 0, lpulses = 0;
    // pulse counts and pin relations watched every cycle
    always @(posedge clock) begin
        if (st && !st_q) steps++;
        if (wd && !wd_q) wpulses++;
        if (wd && !wd_q && early) epulses++;
        if (wd && !wd_q && late) lpulses++;
        if (((early || late) && !wd) || (wd && !wg) || (st && dir !== dir_q)) bad++;
        st_q <= st;
        wd_q <= wd;
        dir_q <= dir;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
        @(negedge clock);
    endtask
    // read data are taken in the cycle after the strobe, the only cycle they stand
    task automatic rd(input logic [1:0] a);
        @(posedge clock);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask
    // bounded wait; running out counts as a mismatch
    task automatic wait_hi(ref logic s, input int n);
        while (s !== 1'b1 && n > 0) begin
            @(negedge clock);
            n--;
        end
        if (s !== 1'b1) chk(8'h00, 8'h01);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog: the tests need about 1200 cycles, so 10000 is ample
    initial begin
        #1000000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clock);
        chk({5'h00, side, trq_oe_n, irq_oe_n}, 8'h03);
        rstn <= 1'b1;
        wr(2'h0, 8'h00);
        wait_hi(irq, 400);
        chk({steps[6:0], dir}, 8'h03);
        chk({7'h00, irq_oe_n}, 8'h00);
        rd(2'h0);
        chk({v[7], irq}, 8'h02);
        // a side flag in a step command must leave the side output alone
        wr(2'h0, 8'h48);
        wait_hi(irq, 400);
        chk({steps[5:0], dir, side}, 8'h08);
        $display("step test done");
        wr(2'h1, 8'h32);
        rd(2'h1);
        chk(v, 8'h32);
        wr(2'h0, 8'h88);
        wait_hi(trq, 1000);
        chk({3'h0, side, zone, sg, hl, trq_oe_n}, 8'h1e);
        rd(2'h3);
        chk(v, 8'hff);
        chk({7'h00, trq}, 8'h00);
        wait_hi(irq, 1000);
        chk({6'h00, zone, hl}, 8'h00);
        $display("read test done");
        wr(2'h0, 8'hc8);
        wait_hi(trq, 1000);
        chk({6'h00, wg, side}, 8'h03);
        // 0x6a has four ones: one needs a late mark, one an early mark
        wr(2'h3, 8'h6a);
        wait_hi(irq, 2000);
        chk(wpulses[7:0], 8'h04);
        chk({epulses[3:0], lpulses[3:0]}, 8'h11);
        chk(bad[7:0], 8'h00);
        $display("write test done");
        // master reset while idle after the write command must pull side select low at once
        @(posedge clock);
        rstn <= 1'b0;
        @(negedge clock);
        chk({6'h00, side, irq_oe_n}, 8'h01);
        $display("reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
